// File: core/gptim_pkg.sv
// Purpose: constants, register map and types of the general purpose timer
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes:   every register is one 32-bit word; narrow fields sit in the low bits
//
// Behaviour
// [RULE1] the full variant has a 16-bit auto-reload counter counting up, down or center-aligned.
// [RULE2] a 16-bit prescaler divides the counting clock by any integer from 1 to 65536.
// [RULE3] the full variant has four channels, each capture, compare, pwm or one-pulse.
// [RULE4] the full variant raises its own dma request, independent of other timers.
// [RULE5] in encoder mode two quadrature inputs set both the count and its direction.
// [RULE6] the full variant takes one to three hall sensor lines as capture inputs.
// [RULE7] a timer can be linked to another so that its events sync or chain the other; here a link trigger only restarts the counter, nothing chains.
// [RULE8] with debug freeze enabled the counter holds while the processor is halted.
// [RULE9] the dual variant counts up, down or up/down, has two channels and no dma.
// [RULE10] the single variant counts up only, has one channel and no dma.
// [RULE11] reduced variants can count from the 32.768 kHz low speed clock.
// [RULE12] the basic variant is an up-counting time base with no channels but with dma.
// [RULE13] every timer drives an update event output for dac triggering and dma.
// [RULE14] timer events are routed out as start triggers for the adc.
// [RULE15] overflow or underflow reloads the counter, sets the update flag and pulses update.
package gptim_pkg;

  // variants
  localparam logic [1:0] VAR_FULL   = 2'h0;
  localparam logic [1:0] VAR_DUAL   = 2'h1;
  localparam logic [1:0] VAR_SINGLE = 2'h2;
  localparam logic [1:0] VAR_BASIC  = 2'h3;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PSC    = 8'h04;
  localparam logic [7:0] ADDR_ARR    = 8'h08;
  localparam logic [7:0] ADDR_CNT    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CLEAR  = 8'h14;
  localparam logic [7:0] ADDR_IRQEN  = 8'h18;
  localparam logic [7:0] ADDR_CHMODE = 8'h1c;
  localparam logic [7:0] ADDR_CCR0   = 8'h20;

  // control field positions
  localparam int CTRL_EN     = 0;
  localparam int CTRL_DIR    = 1;
  localparam int CTRL_CENTER = 2;
  localparam int CTRL_ENC    = 3;
  localparam int CTRL_HALL   = 4;
  localparam int CTRL_FREEZE = 5;
  localparam int CTRL_SLOW   = 6;
  localparam int CTRL_LINK   = 7;
  localparam int CTRL_DMA    = 8;
  localparam int CTRL_W      = 9;

  // status: bit 0 update, bits 1..4 channel events
  localparam int STAT_UPD = 0;
  localparam int STAT_W   = 5;
  localparam int NCH_MAX  = 4;

  // channel modes, two bits per channel
  localparam logic [1:0] CH_CAPTURE = 2'h0;
  localparam logic [1:0] CH_COMPARE = 2'h1;
  localparam logic [1:0] CH_PWM     = 2'h2;
  localparam logic [1:0] CH_PULSE   = 2'h3;

  localparam logic [15:0] RST_ARR = 16'hffff;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DN = 1'b1
  } gptim_dir_t;

  function automatic int nch(input logic [1:0] v);
    case (v)
      VAR_FULL:   nch = 4;
      VAR_DUAL:   nch = 2;
      VAR_SINGLE: nch = 1;
      default:    nch = 0;
    endcase
  endfunction

  function automatic logic has_dma(input logic [1:0] v);
    has_dma = (v == VAR_FULL) || (v == VAR_BASIC);
  endfunction

  function automatic logic up_only(input logic [1:0] v);
    up_only = (v == VAR_SINGLE) || (v == VAR_BASIC);
  endfunction

endpackage

// File: core/gptim_timer.sv
// Purpose: general purpose 16-bit timer, all variants from one source
// Assumes: all inputs synchronous to clk_in; low speed clock sampled as a level
// Notes:   variant fixed by VARIANT; missing features do nothing, and ccr registers of missing channels read as zero
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module gptim_timer #(
  parameter logic [1:0] VARIANT = gptim_pkg::VAR_FULL
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // pins and system signals
  input  wire logic [3:0]  ch_in,
  input  wire logic        enc_a_in,
  input  wire logic        enc_b_in,
  input  wire logic [2:0]  hall_in,
  input  wire logic        slow_clk_in,
  input  wire logic        debug_halt_in,
  input  wire logic        link_trig_in,
  output logic      [3:0]  ch_out,
  output logic             update_out,
  output logic             trgo_out,
  output logic             dma_req_out,
  output logic             irq_out
);

  localparam int  NCH   = gptim_pkg::nch(VARIANT);
  localparam logic DMA  = gptim_pkg::has_dma(VARIANT);
  localparam logic UPON = gptim_pkg::up_only(VARIANT);

  typedef struct packed {
    logic [gptim_pkg::CTRL_W-1:0]  ctrl;
    logic [15:0]                   psc;
    logic [15:0]                   pcnt;
    logic [15:0]                   arr;
    logic [15:0]                   cnt;
    logic [3:0][15:0]              ccr;
    logic [7:0]                    chmode;
    logic [gptim_pkg::STAT_W-1:0]  status;
    logic [gptim_pkg::STAT_W-1:0]  irqen;
    gptim_pkg::gptim_dir_t         cdir;
    logic [3:0]                    ch_prev;
    logic [3:0]                    chout;
    logic                          a_prev;
    logic [2:0]                    hall_prev;
    logic                          slow_prev;
    logic                          upd;
    logic                          trgo;
    logic                          dma;
    logic                          irq;
    logic [31:0]                   rdata;
  } gptim_state_t;

  gptim_state_t q;
  gptim_state_t next_q;
  logic         step;
  logic         down;
  logic         run;
  logic [gptim_pkg::STAT_W-1:0] ev;

  always_comb begin
    logic src_tick;
    logic trig;
    logic [1:0] md;
    src_tick = 1'b0;
    trig     = 1'b0;
    md       = 2'h0;
    next_q       = q;
    next_q.upd   = 1'b0;
    next_q.trgo  = 1'b0;
    next_q.dma   = 1'b0;
    next_q.rdata = '0;
    step = 1'b0;
    ev   = '0;
    next_q.slow_prev = slow_clk_in;
    next_q.a_prev    = enc_a_in;
    next_q.hall_prev = hall_in;
    next_q.ch_prev   = ch_in;
    // with freeze enabled, a halted cpu holds the count so breakpoints see a stable value
    run = q.ctrl[gptim_pkg::CTRL_EN] &&
          !(q.ctrl[gptim_pkg::CTRL_FREEZE] && debug_halt_in); // see [RULE8]
    // only reduced variants may count from the low speed clock
    src_tick = (q.ctrl[gptim_pkg::CTRL_SLOW] && VARIANT != gptim_pkg::VAR_FULL) ?
               (slow_clk_in && !q.slow_prev) : 1'b1; // see [RULE11]
    if (q.ctrl[gptim_pkg::CTRL_ENC] && VARIANT == gptim_pkg::VAR_FULL) begin
      // x2 decode on channel a; direction from the phase of b
      step = run && (enc_a_in != q.a_prev); // see [RULE5]
      down = (enc_a_in == enc_b_in);
    end else begin
      if (run && src_tick) begin
        // a ratio written below the running count ends the period at once, no 65536 wrap
        if (q.pcnt >= q.psc) begin
          next_q.pcnt = '0;
          step = 1'b1; // see [RULE2]
        end else begin
          next_q.pcnt = q.pcnt + 16'h0001;
        end
      end
      if (UPON) begin
        down = 1'b0; // see [RULE10] [RULE12]
      end else if (q.ctrl[gptim_pkg::CTRL_CENTER]) begin
        down = (q.cdir == gptim_pkg::DIR_DN);
      end else begin
        down = q.ctrl[gptim_pkg::CTRL_DIR]; // see [RULE1] [RULE9]
      end
    end
    trig = q.ctrl[gptim_pkg::CTRL_LINK] && link_trig_in;
    if (trig) begin
      // another timer's event restarts this one
      next_q.cnt  = '0; // see [RULE7]
      next_q.pcnt = '0;
      next_q.cdir = gptim_pkg::DIR_UP;
    end else if (step) begin
      if (!down) begin
        if (q.cnt == q.arr) begin
          next_q.upd = 1'b1; // see [RULE15]
          if (q.ctrl[gptim_pkg::CTRL_CENTER] && !UPON) begin
            next_q.cdir = gptim_pkg::DIR_DN;
            next_q.cnt  = (q.arr == 16'h0000) ? 16'h0000 : q.arr - 16'h0001;
          end else begin
            next_q.cnt = '0;
          end
        end else begin
          next_q.cnt = q.cnt + 16'h0001;
        end
      end else begin
        if (q.cnt == 16'h0000) begin
          next_q.upd = 1'b1; // see [RULE15]
          if (q.ctrl[gptim_pkg::CTRL_CENTER]) begin
            next_q.cdir = gptim_pkg::DIR_UP;
            next_q.cnt  = (q.arr == 16'h0000) ? 16'h0000 : 16'h0001;
          end else begin
            next_q.cnt = q.arr;
          end
        end else begin
          next_q.cnt = q.cnt - 16'h0001;
        end
      end
    end
    ev[gptim_pkg::STAT_UPD] = next_q.upd;
    next_q.trgo = next_q.upd; // see [RULE13] [RULE14]
    for (int i = 0; i < gptim_pkg::NCH_MAX; i++) begin
      if (i < NCH) begin // see [RULE3]
        md = q.chmode[2*i +: 2];
        case (md)
          gptim_pkg::CH_CAPTURE: begin
            // channel 0 in hall mode latches on any sensor change
            if ((i == 0 && q.ctrl[gptim_pkg::CTRL_HALL] && VARIANT == gptim_pkg::VAR_FULL) ?
                (hall_in != q.hall_prev) : (ch_in[i] && !q.ch_prev[i])) begin
              next_q.ccr[i] = q.cnt; // see [RULE6]
              ev[i+1] = 1'b1;
            end
          end
          gptim_pkg::CH_COMPARE: begin
            if (step && next_q.cnt == q.ccr[i]) begin
              next_q.chout[i] = !q.chout[i];
              ev[i+1] = 1'b1;
            end
          end
          gptim_pkg::CH_PWM: begin
            next_q.chout[i] = (next_q.cnt < q.ccr[i]);
            ev[i+1] = step && (next_q.cnt == q.ccr[i]);
          end
          gptim_pkg::CH_PULSE: begin
            if (step && next_q.cnt == q.ccr[i]) begin
              next_q.chout[i] = 1'b1;
              ev[i+1] = 1'b1;
            end
            // one pulse ends the run at the next update
            if (next_q.upd) begin
              next_q.chout[i] = 1'b0;
              next_q.ctrl[gptim_pkg::CTRL_EN] = 1'b0;
            end
          end
          default: begin
            next_q.chout[i] = 1'b0;
          end
        endcase
      end
    end
    next_q.dma = DMA && q.ctrl[gptim_pkg::CTRL_DMA] && (|ev); // see [RULE4] [RULE13]
    if (wr_in) begin
      case (addr_in)
        gptim_pkg::ADDR_CTRL:   next_q.ctrl   = wdata_in[gptim_pkg::CTRL_W-1:0];
        gptim_pkg::ADDR_PSC:    next_q.psc    = wdata_in[15:0];
        gptim_pkg::ADDR_ARR:    next_q.arr    = wdata_in[15:0];
        gptim_pkg::ADDR_CNT:    next_q.cnt    = wdata_in[15:0];
        gptim_pkg::ADDR_IRQEN:  next_q.irqen  = wdata_in[gptim_pkg::STAT_W-1:0];
        gptim_pkg::ADDR_CHMODE: next_q.chmode = wdata_in[7:0];
        default: begin
          for (int k = 0; k < gptim_pkg::NCH_MAX; k++) begin
            if (k < NCH && addr_in == gptim_pkg::ADDR_CCR0 + 8'(4*k)) begin
              next_q.ccr[k] = wdata_in[15:0];
            end
          end
        end
      endcase
    end
    // a new event outlives a clear written in the same cycle
    next_q.status = q.status & ~((wr_in && addr_in == gptim_pkg::ADDR_CLEAR) ?
                    wdata_in[gptim_pkg::STAT_W-1:0] : '0);
    next_q.status = next_q.status | ev;
    next_q.irq = |(next_q.status & next_q.irqen);
    if (rd_in) begin
      case (addr_in)
        gptim_pkg::ADDR_CTRL:   next_q.rdata = 32'(q.ctrl);
        gptim_pkg::ADDR_PSC:    next_q.rdata = 32'(q.psc);
        gptim_pkg::ADDR_ARR:    next_q.rdata = 32'(q.arr);
        gptim_pkg::ADDR_CNT:    next_q.rdata = 32'(q.cnt);
        gptim_pkg::ADDR_STATUS: next_q.rdata = 32'(q.status);
        gptim_pkg::ADDR_IRQEN:  next_q.rdata = 32'(q.irqen);
        gptim_pkg::ADDR_CHMODE: next_q.rdata = 32'(q.chmode);
        default: begin
          for (int k = 0; k < gptim_pkg::NCH_MAX; k++) begin
            if (k < NCH && addr_in == gptim_pkg::ADDR_CCR0 + 8'(4*k)) begin
              next_q.rdata = 32'(q.ccr[k]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      q     <= '0;
      q.arr <= gptim_pkg::RST_ARR;
    end else begin
      q <= next_q;
    end
  end

  assign rdata_out   = q.rdata;
  assign ch_out      = q.chout;
  assign update_out  = q.upd;
  assign trgo_out    = q.trgo;
  assign dma_req_out = q.dma;
  assign irq_out     = q.irq;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_top_step;
    step && !down && q.cnt == q.arr && !wr_in && !(q.ctrl[gptim_pkg::CTRL_LINK] && link_trig_in);
  endsequence
  sequence s_wrapped;
    update_out && trgo_out && q.status[gptim_pkg::STAT_UPD];
  endsequence

  property p_up_wrap;
    s_top_step and !q.ctrl[gptim_pkg::CTRL_CENTER] |=> q.cnt == 16'h0000 ##0 s_wrapped;
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("no reload at top"); // see [RULE15]

  property p_down_wrap;
    step && down && q.cnt == 16'h0000 && !wr_in && !q.ctrl[gptim_pkg::CTRL_CENTER] &&
    !(q.ctrl[gptim_pkg::CTRL_LINK] && link_trig_in) |=> q.cnt == $past(q.arr) && update_out;
  endproperty
  a_down_wrap: assert property (p_down_wrap) else $error("no reload at zero"); // see [RULE1]

  property p_psc_div;
    step && !q.ctrl[gptim_pkg::CTRL_ENC] && !wr_in |=> q.pcnt == 16'h0000;
  endproperty
  a_psc_div: assert property (p_psc_div) else $error("prescaler not restarted"); // see [RULE2]

  property p_freeze;
    q.ctrl[gptim_pkg::CTRL_FREEZE] && debug_halt_in && !wr_in && !link_trig_in |=>
      $stable(q.cnt) && !update_out;
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while halted"); // see [RULE8]

  property p_irq;
    irq_out == |(q.status & q.irqen);
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not match status"); // see [RULE13]

  property p_set_wins;
    ev[gptim_pkg::STAT_UPD] |=> q.status[gptim_pkg::STAT_UPD];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("update flag lost"); // see [RULE15]

  property p_capture;
    NCH > 0 && q.chmode[1:0] == gptim_pkg::CH_CAPTURE && !q.ctrl[gptim_pkg::CTRL_HALL] &&
    ch_in[0] && !q.ch_prev[0] && !wr_in |=> q.ccr[0] == $past(q.cnt) && q.status[1];
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed"); // see [RULE3]

  property p_no_dma;
    !DMA |-> !dma_req_out;
  endproperty
  a_no_dma: assert property (p_no_dma) else $error("dma from variant without dma"); // see [RULE9]

  property p_up_only;
    UPON && step && !wr_in && !link_trig_in && q.cnt != q.arr |=> q.cnt == $past(q.cnt) + 16'h0001;
  endproperty
  a_up_only: assert property (p_up_only) else $error("up-only variant not counting up"); // see [RULE10]

  property p_read;
    rd_in && addr_in == gptim_pkg::ADDR_STATUS |=> rdata_out == 32'($past(q.status));
  endproperty
  a_read: assert property (p_read) else $error("status read wrong"); // see [RULE13]

endmodule

// File: test/gptim_sensor.sv
// Purpose: model of the encoder, hall sensors and capture sources outside the timer
// Assumes: commands arrive from the bench just after rising edges of clk_in
// Notes:   encoder lines move one at a time, b first, so a step needs two cycles
`timescale 1ns/100ps
module gptim_sensor (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // commands from the bench
  input  wire logic       step_in,
  input  wire logic       down_in,
  input  wire logic       hall_step_in,
  input  wire logic [3:0] cap_in,
  // lines to the timer
  output logic            enc_a_out,
  output logic            enc_b_out,
  output logic      [2:0] hall_out,
  output logic      [3:0] cap_out
);
  logic pend;

  initial begin
    {enc_a_out, enc_b_out, pend} = 3'h0;
    hall_out = 3'h1;
    cap_out = 4'h0;
  end

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      {enc_a_out, enc_b_out, pend} <= 3'h0;
      hall_out <= 3'h1;
      cap_out <= 4'h0;
    end else begin
      cap_out <= cap_in;
      pend <= step_in;
      // b is placed first so the coming a edge reads as the wanted direction
      if (step_in)
        enc_b_out <= down_in ? ~enc_a_out : enc_a_out;
      if (pend)
        enc_a_out <= ~enc_a_out;
      // one line changes per step, as real sensors do
      if (hall_step_in)
        hall_out <= {hall_out[1:0], ~hall_out[2]};
    end
  end
endmodule

// File: test/general_purpose_timer_tb.sv
// Purpose: self-checking bench of the full timer variant, with a single-channel one beside it
// Assumes: register port with read data one cycle after the strobe
// Notes:   counting cases sit in a table; the rest are hand-written after it
`timescale 1ns/100ps
module general_purpose_timer_tb;
  typedef struct {logic [31:0] ctrl; logic [31:0] psc; logic [31:0] arr; logic [31:0] per;} gptim_row_t;
  logic        clk_in    = 1'b0;
  logic        resetn_in = 1'b0;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        halt      = 1'b0;
  logic        link      = 1'b0;
  logic        slow_clk  = 1'b0;
  logic        step      = 1'b0;
  logic        down      = 1'b0;
  logic        hstep     = 1'b0;
  logic [3:0]  cap       = 4'h0;
  logic [31:0] rdata, rdata_s, got, first;
  logic [3:0]  ch_in, ch_out;
  logic [2:0]  hall;
  logic        enc_a, enc_b, update, trgo, dma, irq;
  int          num_errors = 0;
  int          check_count = 0;
  int          n, hi;
  gptim_row_t  rows [5] = '{'{32'h101, 32'h0, 32'h2, 32'h3}, '{32'h001, 32'h3, 32'h4, 32'h14},
                            '{32'h103, 32'h1, 32'h5, 32'hc}, '{32'h105, 32'h0, 32'h5, 32'h5},
                            '{32'h101, 32'h0, 32'h1, 32'h2}};

  always #50 clk_in = ~clk_in;

  gptim_timer u_gptim_timer (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ch_in(ch_in),
    .enc_a_in(enc_a), .enc_b_in(enc_b), .hall_in(hall), .slow_clk_in(slow_clk),
    .debug_halt_in(halt), .link_trig_in(link), .ch_out(ch_out), .update_out(update),
    .trgo_out(trgo), .dma_req_out(dma), .irq_out(irq));
  gptim_sensor u_gptim_sensor (.clk_in(clk_in), .resetn_in(resetn_in), .step_in(step),
    .down_in(down), .hall_step_in(hstep), .cap_in(cap), .enc_a_out(enc_a),
    .enc_b_out(enc_b), .hall_out(hall), .cap_out(ch_in));
  // single-channel variant shares the bus, so every write lands in both timers
  gptim_timer #(.VARIANT(gptim_pkg::VAR_SINGLE)) u_gptim_timer_single (.clk_in(clk_in),
    .resetn_in(resetn_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata_s), .ch_in(ch_in), .enc_a_in(enc_a), .enc_b_in(enc_b),
    .hall_in(hall), .slow_clk_in(slow_clk), .debug_halt_in(halt), .link_trig_in(link),
    .ch_out(), .update_out(), .trgo_out(), .dma_req_out(), .irq_out());

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a, got);
    chk(got, exp);
  endtask

  task automatic wait_upd;
    for (n = 0; n < 300 && update !== 1'b1; n++)
      cyc(1);
    if (update !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic enc_step(input logic dn);
    @(posedge clk_in);
    step <= 1'b1;
    down <= dn;
    @(posedge clk_in);
    step <= 1'b0;
    cyc(3);
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    // first update only aligns the prescaler; the next interval is measured
    for (int i = 0; i < 5; i++) begin
      wr_reg(gptim_pkg::ADDR_CTRL, 32'h0);
      wr_reg(gptim_pkg::ADDR_CNT, 32'h0);
      wr_reg(gptim_pkg::ADDR_PSC, rows[i].psc);
      wr_reg(gptim_pkg::ADDR_ARR, rows[i].arr);
      wr_reg(gptim_pkg::ADDR_CTRL, rows[i].ctrl);
      wait_upd();
      for (n = 1; n <= 300; n++) begin
        cyc(1);
        chk(trgo, update);
        chk(dma, update & rows[i].ctrl[8]);
        if (update === 1'b1)
          break;
      end
      chk(n, rows[i].per);
    end
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h0);
    wr_reg(gptim_pkg::ADDR_IRQEN, 32'h1);
    cyc(2);
    chk(irq, 1'b1);
    rd_chk(gptim_pkg::ADDR_STATUS, 32'h1);
    wr_reg(gptim_pkg::ADDR_IRQEN, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    wr_reg(gptim_pkg::ADDR_IRQEN, 32'h1);
    wr_reg(gptim_pkg::ADDR_CLEAR, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    rd_chk(gptim_pkg::ADDR_STATUS, 32'h0);
    rd_chk(8'h40, 32'h0);
    rd_chk(gptim_pkg::ADDR_CLEAR, 32'h0);
    // halted cpu: counter holds only while freeze is enabled
    wr_reg(gptim_pkg::ADDR_ARR, 32'hffff);
    wr_reg(gptim_pkg::ADDR_PSC, 32'h0);
    @(posedge clk_in);
    halt <= 1'b1;
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h21);
    rd_reg(gptim_pkg::ADDR_CNT, first);
    cyc(4);
    rd_chk(gptim_pkg::ADDR_CNT, first);
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h1);
    rd_reg(gptim_pkg::ADDR_CNT, first);
    rd_chk(gptim_pkg::ADDR_CNT, first + 32'h2);
    halt <= 1'b0;
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h81);
    @(posedge clk_in);
    link <= 1'b1;
    rd_chk(gptim_pkg::ADDR_CNT, 32'h0);
    link <= 1'b0;
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h0);
    wr_reg(gptim_pkg::ADDR_CNT, 32'h0);
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h9);
    for (int i = 0; i < 4; i++)
      enc_step(i == 3);
    rd_chk(gptim_pkg::ADDR_CNT, 32'h2);
    wr_reg(gptim_pkg::ADDR_CLEAR, 32'h1f);
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h1);
    @(posedge clk_in);
    // channels 0 and 1 both rise, so the channel 0 capture check is reached too
    cap <= 4'h3;
    cyc(4);
    cap <= 4'h0;
    rd_chk(gptim_pkg::ADDR_STATUS, 32'h6);
    wr_reg(gptim_pkg::ADDR_CLEAR, 32'h1f);
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h11);
    @(posedge clk_in);
    hstep <= 1'b1;
    @(posedge clk_in);
    hstep <= 1'b0;
    cyc(3);
    rd_chk(gptim_pkg::ADDR_STATUS, 32'h2);
    // pwm high while count is below ccr: two of every five cycles
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h0);
    wr_reg(gptim_pkg::ADDR_CNT, 32'h0);
    wr_reg(gptim_pkg::ADDR_ARR, 32'h4);
    wr_reg(gptim_pkg::ADDR_CCR0, 32'h2);
    wr_reg(gptim_pkg::ADDR_CHMODE, 32'h2);
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h1);
    cyc(10);
    hi = 0;
    for (int i = 0; i < 50; i++) begin
      cyc(1);
      hi += (ch_out[0] === 1'b1) ? 1 : 0;
    end
    chk(hi, 32'h14);
    // one-pulse on channel 0, compare toggle on channel 1, over the single period it allows
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h0);
    wr_reg(gptim_pkg::ADDR_CNT, 32'h0);
    wr_reg(gptim_pkg::ADDR_CCR0 + 8'h04, 32'h1);
    wr_reg(gptim_pkg::ADDR_CHMODE, 32'h7);
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h1);
    cyc(10);
    chk(ch_out, 4'h2);
    rd_chk(gptim_pkg::ADDR_CTRL, 32'h0);
    // single variant ignores the down bit and steps only on slow clock rises
    wr_reg(gptim_pkg::ADDR_CNT, 32'h0);
    wr_reg(gptim_pkg::ADDR_CTRL, 32'h143);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_in);
      slow_clk <= ~slow_clk;
    end
    rd_reg(gptim_pkg::ADDR_CNT, got);
    chk(rdata_s, 32'h3);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd_chk(gptim_pkg::ADDR_ARR, 32'h0000ffff);
    rd_chk(gptim_pkg::ADDR_CTRL, 32'h0);
    rd_chk(gptim_pkg::ADDR_PSC, 32'h0);
    chk({irq, ch_out}, 5'h00);
    conclude();
  end
endmodule
